/* hdl/occr_regs.v */
// apb register slice for output channels 1 and 2 and the ch0/1 divider
// Contract
// - format field 0 off, 1 ac differential, 2 hcsl, 3 lvcmos; reset 1.
// - mode a sets tail current 4/6/8/16 mA; code 3 8 mA on lvpecl.
// - in lvcmos, mode a drives positive pin powerdown and polarity.
// - mode b sets hcsl load or negative pin in lvcmos; reset 0.
// - shared ch0/1 divider divides by field plus one; reset 0x01.
// - all 256 divider codes are legal, ratio 1 through 256.
// - source bit picks first synthesizer at 0, second at 1; reset 1.
`timescale 1ns/100ps
`include "occr_defs.vh"
module occr_regs (
   input  wire        clock,         // 125 MHz system clock
   input  wire        sys_rst,       // synchronous reset, active high
   input  wire        psel,          // apb select
   input  wire        penable,       // apb access phase
   input  wire        pwrite,        // apb direction, 1 = write
   input  wire [11:0] paddr,         // apb byte address
   input  wire [31:0] pwdata,        // apb write data
   input  wire [3:0]  pstrb,         // apb byte strobes
   output wire        pready,        // apb ready, always high
   output reg  [31:0] prdata,        // apb read data
   output wire        pslverr,       // apb error on unmapped address
   output wire [1:0]  ch_one_fmt,    // channel 1 driver format
   output wire [1:0]  ch_one_drive_mode_a, // channel 1 mode a field
   output wire [1:0]  ch_one_drive_mode_b, // channel 1 mode b field
   output wire [1:0]  ch_two_fmt,    // channel 2 driver format
   output wire [1:0]  ch_two_drive_mode_a, // channel 2 mode a field
   output wire [1:0]  ch_two_drive_mode_b, // channel 2 mode b field
   output wire        ch_two_three_source_select, // 0 first, 1 second
   output wire        ch_two_three_from_second,   // src is second synth
   output wire [7:0]  ch_zero_one_div_code, // raw divider code
   output wire [8:0]  ch_zero_one_div_ratio, // divide ratio 1..256
   output wire        ch_one_drv_en,  // channel 1 driver on
   output wire [4:0]  ch_one_tail_ma, // channel 1 tail current, mA
   output wire [7:0]  ch_one_load_ohm, // channel 1 hcsl load, ohm
   output wire [1:0]  ch_one_pin_p,  // channel 1 lvcmos p pin code
   output wire [1:0]  ch_one_pin_n,  // channel 1 lvcmos n pin code
   output wire        ch_two_drv_en,  // channel 2 driver on
   output wire [4:0]  ch_two_tail_ma, // channel 2 tail current, mA
   output wire [7:0]  ch_two_load_ohm, // channel 2 hcsl load, ohm
   output wire [1:0]  ch_two_pin_p,  // channel 2 lvcmos p pin code
   output wire [1:0]  ch_two_pin_n   // channel 2 lvcmos n pin code
);
   // 9-bit ratio so code 0xFF maps to 256 without wrap
   function [8:0] div_ratio;
      input [7:0] code;
      begin
         div_ratio = {1'b0, code} + 9'h001;
      end
   endfunction

   // word address match against a printed index; the low two address
   // bits must be zero, so a byte-offset access misses every register
   function hit;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         hit = (addr == {2'b00, idx, 2'b00});
      end
   endfunction

   // clears reserved bit 0 of a control byte before it is stored
   function [7:0] ctl_clean;
      input [7:0] wbyte;
      begin
         ctl_clean = {wbyte[7:1], 1'b0};
      end
   endfunction

   // widens a stored byte to a bus word; upper lanes always read zero
   function [31:0] rd_word;
      input [7:0] byte_val;
      begin
         rd_word = {24'h000000, byte_val};
      end
   endfunction

   // bit map of the two control bytes (bit 7 differs between them):
   //   7    reserved in control one, source select in control two
   //   6:5  driver format
   //   4:3  drive mode a: tail current or positive pin code
   //   2:1  drive mode b: hcsl load or negative pin code
   //   0    reserved in both, never stored, reads zero
   // the divider byte is all code; every value is a legal ratio
   // reset contents follow from the field defaults in the header
   localparam [6:0] OUT1_RST = {`OCCR_RST_SEL, `OCCR_RST_MODEA,
                                `OCCR_RST_MODEB, 1'b0};
   localparam [7:0] OUT2_RST = {`OCCR_RST_MUX, `OCCR_RST_SEL,
                                `OCCR_RST_MODEA, `OCCR_RST_MODEB, 1'b0};

   // stored bits and their next values
   reg [6:0]  out1_q;   // bits 6..1 used; bit 7 and 0 reserved
   reg [7:0]  div01_q;  // full-width divider code
   reg [7:0]  out2_q;   // bit 7 source select, bit 0 reserved
   reg [6:0]  out1_d;   // next value of out1_q
   reg [7:0]  div01_d;  // next value of div01_q
   reg [7:0]  out2_d;   // next value of out2_q
   reg [31:0] prdata_d; // next value of the read data

   // address decode, shared by the write and the read path
   wire sel_out1  = hit(paddr, `OCCR_IDX_OUT1_CTL);
   wire sel_div01 = hit(paddr, `OCCR_IDX_OUT01_DIV);
   wire sel_out2  = hit(paddr, `OCCR_IDX_OUT2_CTL);
   wire mapped    = sel_out1 | sel_div01 | sel_out2;
   // only the low byte lane holds data; its strobe gates the write
   wire wr_en     = psel & penable & pwrite & pstrb[0];
   // per-register write strobes and the cleaned control byte
   wire       wr_out1  = wr_en & sel_out1;
   wire       wr_div01 = wr_en & sel_div01;
   wire       wr_out2  = wr_en & sel_out2;
   wire [7:0] wr_ctl   = ctl_clean(pwdata[7:0]);

   // a read is launched only while the setup phase is on the bus;
   // the access phase then just presents the stored word
   wire       rd_setup = psel & ~penable & ~pwrite;

   // zero-wait slave: a transfer ends in its first access cycle
   assign pready  = 1'b1;
   // error flag only while an access to an unmapped word is on the bus
   assign pslverr = psel & penable & ~mapped;

   // next values: hold unless a strobed write hits the register
   always @* begin
      out1_d  = out1_q;
      div01_d = div01_q;
      out2_d  = out2_q;
      if (wr_out1)
         out1_d = wr_ctl[6:0];
      if (wr_div01)
         div01_d = pwdata[7:0];
      if (wr_out2)
         out2_d = wr_ctl;
   end

   // register update; a write lands at the edge that ends its access
   // phase, so the new field drives the output path from the next cycle
   always @(posedge clock) begin
      if (sys_rst) begin
         out1_q  <= OUT1_RST;
         div01_q <= `OCCR_RST_DIV;
         out2_q  <= OUT2_RST;
      end else begin
         out1_q  <= out1_d;
         div01_q <= div01_d;
         out2_q  <= out2_d;
      end
   end

   // read mux; unmapped addresses read zero, reserved bits read zero
   always @* begin
      prdata_d = prdata;
      if (rd_setup) begin
         if (sel_out1)
            prdata_d = rd_word({1'b0, out1_q[6:1], 1'b0});
         else if (sel_div01)
            prdata_d = rd_word(div01_q);
         else if (sel_out2)
            prdata_d = rd_word({out2_q[7:1], 1'b0});
         else
            prdata_d = 32'h00000000;
      end
   end

   // read data is launched at the end of setup, so it is settled for the
   // whole access phase even though pready never stretches it
   always @(posedge clock) begin
      if (sys_rst)
         prdata <= 32'h00000000;
      else
         prdata <= prdata_d;
   end

   // channel 1 fields go straight to the output path, no shadowing
   assign ch_one_fmt          = out1_q[`OCCR_SEL_HI:`OCCR_SEL_LO];
   assign ch_one_drive_mode_a = out1_q[`OCCR_MODEA_HI:`OCCR_MODEA_LO];
   assign ch_one_drive_mode_b = out1_q[`OCCR_MODEB_HI:`OCCR_MODEB_LO];

   // channel 2 fields, same layout as channel 1
   assign ch_two_fmt          = out2_q[`OCCR_SEL_HI:`OCCR_SEL_LO];
   assign ch_two_drive_mode_a = out2_q[`OCCR_MODEA_HI:`OCCR_MODEA_LO];
   assign ch_two_drive_mode_b = out2_q[`OCCR_MODEB_HI:`OCCR_MODEB_LO];

   // source select for channels 2 and 3; both ports carry the same bit
   // so the mux and the status path need no decode of their own
   assign ch_two_three_source_select = out2_q[`OCCR_MUX_BIT];
   assign ch_two_three_from_second   = out2_q[`OCCR_MUX_BIT];

   // shared ch0/1 divider; the ratio is one bit wider than the code so
   // that code 0xFF reaches 256 instead of wrapping to zero
   assign ch_zero_one_div_code  = div01_q;
   assign ch_zero_one_div_ratio = div_ratio(div01_q);

   // channel 1: format and mode codes to driver controls
   occr_chan_decode u_dec_one (
      .fmt       (ch_one_fmt),
      .mode_a    (ch_one_drive_mode_a),
      .mode_b    (ch_one_drive_mode_b),
      .drv_en    (ch_one_drv_en),
      .diff_en   (),
      .cmos_en   (),
      .tail_ma   (ch_one_tail_ma),
      .load_ohm  (ch_one_load_ohm),
      .pin_p_ctl (ch_one_pin_p),
      .pin_n_ctl (ch_one_pin_n)
   );

   // channel 2: same decode, separate instance
   occr_chan_decode u_dec_two (
      .fmt       (ch_two_fmt),
      .mode_a    (ch_two_drive_mode_a),
      .mode_b    (ch_two_drive_mode_b),
      .drv_en    (ch_two_drv_en),
      .diff_en   (),
      .cmos_en   (),
      .tail_ma   (ch_two_tail_ma),
      .load_ohm  (ch_two_load_ohm),
      .pin_p_ctl (ch_two_pin_p),
      .pin_n_ctl (ch_two_pin_n)
   );
endmodule // occr_regs

/* shared/occr_defs.vh */
// constants for the output channel configuration register slice
`ifndef OCCR_DEFS_VH
`define OCCR_DEFS_VH
// register indices as printed; byte address is four times the index
`define OCCR_IDX_OUT1_CTL   8'h20
`define OCCR_IDX_OUT01_DIV  8'h21
`define OCCR_IDX_OUT2_CTL   8'h22
// field positions inside the control registers
`define OCCR_MUX_BIT        7
`define OCCR_SEL_HI         6
`define OCCR_SEL_LO         5
`define OCCR_MODEA_HI       4
`define OCCR_MODEA_LO       3
`define OCCR_MODEB_HI       2
`define OCCR_MODEB_LO       1
// reset values of the fields
`define OCCR_RST_SEL        2'h1
`define OCCR_RST_MODEA      2'h2
`define OCCR_RST_MODEB      2'h0
`define OCCR_RST_MUX        1'h1
`define OCCR_RST_DIV        8'h01
// driver format codes
`define OCCR_FMT_OFF        2'h0
`define OCCR_FMT_ACDIFF     2'h1
`define OCCR_FMT_HCSL       2'h2
`define OCCR_FMT_CMOS       2'h3
`endif

/* hdl/occr_chan_decode.v */
// decodes one channel's format and mode fields into driver controls
`timescale 1ns/100ps
`include "occr_defs.vh"
module occr_chan_decode (
   input  wire [1:0] fmt,         // driver format field
   input  wire [1:0] mode_a,      // first driver mode field
   input  wire [1:0] mode_b,      // second driver mode field
   output reg        drv_en,      // driver enabled
   output reg        diff_en,     // differential (ac or hcsl) active
   output reg        cmos_en,     // lvcmos active
   output reg  [4:0] tail_ma,     // tail current in mA, 0 when unused
   output reg  [7:0] load_ohm,    // hcsl load in ohm, 0 = tristate/unused
   output reg  [1:0] pin_p_ctl,   // positive pin powerdown/polarity code
   output reg  [1:0] pin_n_ctl    // negative pin powerdown/polarity code
);
   // pure decode so a register write reaches the drivers at once
   always @* begin
      drv_en    = (fmt != `OCCR_FMT_OFF);
      diff_en   = (fmt == `OCCR_FMT_ACDIFF) ||
                  (fmt == `OCCR_FMT_HCSL);
      cmos_en   = (fmt == `OCCR_FMT_CMOS);
      tail_ma   = 5'h00;
      load_ohm  = 8'h00;
      pin_p_ctl = 2'h0;
      pin_n_ctl = 2'h0;
      if (diff_en) begin
         case (mode_a)
            2'h0:    tail_ma = 5'h04;
            2'h1:    tail_ma = 5'h06;
            2'h2:    tail_ma = 5'h08;
            // code 3 is 8 mA on ac-lvpecl, 16 mA on hcsl
            default: tail_ma = (fmt == `OCCR_FMT_HCSL) ? 5'h10 : 5'h08;
         endcase
      end
      if (fmt == `OCCR_FMT_HCSL) begin
         case (mode_b)
            2'h0:    load_ohm = 8'h00;
            2'h1:    load_ohm = 8'h32;
            2'h2:    load_ohm = 8'h64;
            default: load_ohm = 8'hC8;
         endcase
      end
      if (cmos_en) begin
         pin_p_ctl = mode_a;
         pin_n_ctl = mode_b;
      end
   end
endmodule // occr_chan_decode

/* verification/occr_regs_sva.sv */
// assertion checker for the output channel register slice
`timescale 1ns/100ps
module occr_regs_sva (
   input wire        clock,                      // clock
   input wire        sys_rst,                    // sync reset
   input wire        psel,                       // select
   input wire        penable,                    // access phase
   input wire        pwrite,                     // direction
   input wire [11:0] paddr,                      // byte address
   input wire [31:0] pwdata,                     // write data
   input wire [3:0]  pstrb,                      // strobes
   input wire [31:0] prdata,                     // read data
   input wire [1:0]  ch_one_fmt,                 // ch1 format
   input wire        ch_one_drv_en,              // ch1 driver on
   input wire [4:0]  ch_one_tail_ma,             // ch1 tail
   input wire        ch_two_three_source_select, // source bit
   input wire [7:0]  ch_zero_one_div_code,       // divider code
   input wire [8:0]  ch_zero_one_div_ratio       // divide ratio
);
   // low byte and mux bit split out so $past sees a plain signal
   wire [7:0] wbyte = pwdata[7:0];
   wire       wmux  = pwdata[7];
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_wr(a); psel && penable && pwrite && pstrb[0] && paddr == a;
   endsequence
   sequence s_rd(a); psel && penable && !pwrite && paddr == a; endsequence
   a_div_ratio: assert property (
      ch_zero_one_div_ratio == ch_zero_one_div_code + 9'h001)
      else $error("divide ratio is not code plus one");
   a_div_write: assert property (
      s_wr(12'h084) |=> ch_zero_one_div_code == $past(wbyte))
      else $error("divider code not taken from write");
   a_mux_write: assert property (
      s_wr(12'h088) |=> ch_two_three_source_select == $past(wmux))
      else $error("source bit not taken from write");
   a_drv_en: assert property (ch_one_drv_en == (ch_one_fmt != 2'h0))
      else $error("driver enable disagrees with format");
   a_tail_off: assert property (
      ch_one_fmt == 2'h0 || ch_one_fmt == 2'h3 |-> ch_one_tail_ma == 5'h00)
      else $error("tail current outside differential format");
   a_rsv_one: assert property (
      s_rd(12'h080) |-> (prdata & 32'hFFFFFF81) == 32'h0)
      else $error("reserved bits of control one read nonzero");
   a_rsv_two: assert property (
      s_rd(12'h088) |-> (prdata & 32'hFFFFFF01) == 32'h0)
      else $error("reserved bits of control two read nonzero");
   a_rst_vals: assert property (
      $fell(sys_rst) |-> ch_zero_one_div_code == 8'h01 &&
      ch_two_three_source_select && ch_one_fmt == 2'h1)
      else $error("field reset values wrong");
endmodule // occr_regs_sva
bind occr_regs occr_regs_sva u_sva (.*);

/* verification/occr_regs_tb_top.sv */
// self-checking bench for the output channel register slice
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("FAIL %s exp %0h got %0h", n, e, g); end end
module occr_regs_tb_top;
   logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [3:0]  pstrb = 4'h0;
   wire         pready, pslverr, ch_two_three_source_select, ch_one_drv_en;
   wire         ch_two_three_from_second, ch_two_drv_en;
   wire  [31:0] prdata;
   wire  [1:0]  ch_one_fmt, ch_one_drive_mode_a, ch_one_drive_mode_b;
   wire  [1:0]  ch_two_fmt, ch_two_drive_mode_a, ch_two_drive_mode_b;
   wire  [1:0]  ch_one_pin_p, ch_one_pin_n, ch_two_pin_p, ch_two_pin_n;
   wire  [4:0]  ch_one_tail_ma, ch_two_tail_ma;
   wire  [7:0]  ch_zero_one_div_code, ch_one_load_ohm, ch_two_load_ohm;
   wire  [8:0]  ch_zero_one_div_ratio;
   int          n_fail = 0, tests_run = 0;
   occr_regs dut (.*);
   always #4 clock = ~clock;
   task wrap_up; begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   end endtask
   // one apb transfer; an idle edge follows so field updates have landed
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int i;
      begin
         psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
         @(posedge clock);
         penable <= 1'b1;
         i = 0;
         do begin @(posedge clock); i++; end while (pready !== 1'b1 && i < 16);
         if (pready !== 1'b1) begin n_fail++; wrap_up; end
         rd = prdata; err = pslverr;
         psel <= 1'b0; penable <= 1'b0;
         @(posedge clock);
      end
   endtask
   task t_reset; begin
      apb(0, 12'h080, 0, 0); `CHK("ctl1", 32'h30, rd)
      apb(0, 12'h084, 0, 0); `CHK("div", 32'h01, rd)
      apb(0, 12'h088, 0, 0); `CHK("ctl2", 32'hB0, rd)
      `CHK("ratio", 9'h002, ch_zero_one_div_ratio)
      `CHK("src", 1'b1, ch_two_three_from_second)
   end endtask
   // every format on channel 1 with reserved bits written as ones
   task t_ch_one; begin
      for (int f = 0; f < 4; f++) begin
         apb(1, 12'h080, {24'h0, 1'b1, f[1:0], 5'h1B}, 4'hF);
         apb(0, 12'h080, 0, 0);
         `CHK("rsv", {24'h0, 1'b0, f[1:0], 5'h1A}, rd)
         `CHK("en", f != 0, ch_one_drv_en)
         `CHK("tail", (f==1) ? 8 : (f==2) ? 16 : 0, ch_one_tail_ma)
         `CHK("load", (f==2) ? 50 : 0, ch_one_load_ohm)
         `CHK("fmt", f[1:0], ch_one_fmt)
         `CHK("mode_a", 2'h3, ch_one_drive_mode_a)
         `CHK("mode_b", 2'h1, ch_one_drive_mode_b)
         `CHK("pin_p", (f==3) ? 2'h3 : 2'h0, ch_one_pin_p)
         `CHK("pin_n", (f==3) ? 2'h1 : 2'h0, ch_one_pin_n)
      end
   end endtask
   // mode sweep on channel 2 in ac, hcsl and lvcmos, source bit toggled
   task t_ch_two; begin
      for (int m = 0; m < 4; m++) begin
         apb(1, 12'h088, {24'h0, 3'h1, m[1:0], m[1:0], 1'b0}, 4'h1);
         `CHK("tail_ac", (m==3) ? 8 : 4 + 2*m, ch_two_tail_ma)
         apb(1, 12'h088, {24'h0, 3'h2, m[1:0], m[1:0], 1'b0}, 4'h1);
         `CHK("tail_hcsl", (m==3) ? 16 : 4 + 2*m, ch_two_tail_ma)
         `CHK("load", (m==0) ? 0 : 25 << m, ch_two_load_ohm)
         `CHK("src", 1'b0, ch_two_three_source_select)
         apb(1, 12'h088, {24'h0, 3'h7, m[1:0], ~m[1:0], 1'b0}, 4'h1);
         `CHK("fmt2", 2'h3, ch_two_fmt)
         `CHK("en2", 1'b1, ch_two_drv_en)
         `CHK("mode_a2", m[1:0], ch_two_drive_mode_a)
         `CHK("mode_b2", ~m[1:0], ch_two_drive_mode_b)
         `CHK("pin_p2", m[1:0], ch_two_pin_p)
         `CHK("pin_n2", ~m[1:0], ch_two_pin_n)
         `CHK("tail_cmos", 5'h00, ch_two_tail_ma)
         `CHK("src2", 1'b1, ch_two_three_from_second)
      end
   end endtask
   // divider boundaries, a strobe-less write and an unmapped access
   task t_div;
      logic [31:0] codes;
      logic [7:0]  c;
      logic [35:0] ratios;
      begin
         codes = 32'h7EFF0100;
         ratios = {9'h07F, 9'h100, 9'h002, 9'h001};
         for (int k = 0; k < 4; k++) begin
            c = codes[8*k +: 8];
            apb(1, 12'h084, {24'h0, c}, 4'h1);
            `CHK("code", c, ch_zero_one_div_code)
            `CHK("ratio", ratios[9*k +: 9], ch_zero_one_div_ratio)
         end
         apb(1, 12'h084, 32'h55, 4'h0);
         apb(1, 12'h08C, 32'hFF, 4'hF);
         `CHK("wr_err", 1'b1, err)
         `CHK("div_kept", 8'h7E, ch_zero_one_div_code)
         apb(0, 12'h08C, 0, 0);
         `CHK("unmapped", 33'h100000000, {err, rd})
      end
   endtask
   // reset in mid-run brings every field back to its default
   task t_mid_reset; begin
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_reset;
   end endtask
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_ch_one;
      t_ch_two;
      t_div;
      t_mid_reset;
      wrap_up;
   end
endmodule // occr_regs_tb_top
